// [shutoff_pkg.sv]
// Overview of operation
// R1: Shutoff input forces channels 1-6 off
// R2: Shutoff input level reported, event latched, auto-release
// R3: Shutoff pin low forces 1-6 off, latched
// R4: Supply faults pull pin low when reset released
// R5: Overvoltage pulls pin at once, undervoltage delayed
// R6: H-bridge channels 7-8 follow every shutoff but the channel 6 disable
// R7: Pin overvoltage past deglitch releases pull-down, latched
// R8: Filtered overvoltage shutoff held until flag read
// R9: Any overvoltage glitch sets flag, no shutoff
// R10: Undervoltage shutoff held filter time after clearing
// R11: Power-on reset resets block, sets flag
// R12: Digital test then analog check, under 3 ms
// R13: Sequence runs on reset release or request
// R14: Digital test three-states outputs, resets configuration
// R15: Digital test walks every shutoff path, timer stop
// R16: Test done flag; failure forces 1-6 off
// R17: Analog check 100-160 us, 1-6 held off
// R18: Any failure keeps 1-6 off, 7-8 usable unless in H-bridge mode
// R19: Reset low or power-on reset aborts sequence
// R20: Battery undervoltage forces all outputs off, latched
// R21: Controller requests self-test before channel configuration
// R22: Sticky flags clear on read, re-set if present
package shutoff_pkg;

  localparam int CLK_PERIOD_NS = 4;
  localparam int PIN_OV_DEGLITCH_NS = 2500;
  localparam int SUPPLY_HIGH_FILTER_NS = 5000;
  localparam int SUPPLY_LOW_FILTER_NS = 10000;
  localparam int SUPPLY_LOW_PIN_DELAY_NS = 10000;
  localparam int BATTERY_FILTER_NS = 5000;
  localparam int SELFCHECK_NS = 128000;

  // Least times round up to whole cycles
  localparam int PIN_OV_CYCLES = (PIN_OV_DEGLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SUPPLY_HIGH_CYCLES = (SUPPLY_HIGH_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SUPPLY_LOW_CYCLES = (SUPPLY_LOW_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SUPPLY_LOW_PIN_CYCLES =
    (SUPPLY_LOW_PIN_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BATTERY_CYCLES = (BATTERY_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SELFCHECK_CYCLES = (SELFCHECK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam logic [15:0] PIN_OV_LIMIT = 16'(PIN_OV_CYCLES);
  localparam logic [15:0] SUPPLY_HIGH_LIMIT = 16'(SUPPLY_HIGH_CYCLES);
  localparam logic [15:0] SUPPLY_LOW_LIMIT = 16'(SUPPLY_LOW_CYCLES);
  localparam logic [15:0] SUPPLY_LOW_PIN_LIMIT = 16'(SUPPLY_LOW_PIN_CYCLES);
  localparam logic [15:0] BATTERY_LIMIT = 16'(BATTERY_CYCLES);

  // Digital self-test walk
  localparam logic [2:0] DIGITAL_SELFTEST_LAST_STEP = 3'h7;
  localparam logic [2:0] DIGITAL_SELFTEST_CH6_STEP = 3'h2;
  localparam logic [2:0] DIGITAL_SELFTEST_SUPPLY_STEP = 3'h6;
  localparam logic [2:0] DIGITAL_SELFTEST_TIMER_RUN_STEP = 3'h5;

  // Channel masks, bit 0 is channel 1
  localparam logic [7:0] CH_NONE = 8'h00;
  localparam logic [7:0] CH_LOW6 = 8'h3F;
  localparam logic [7:0] CH_SIX = 8'h20;
  localparam logic [7:0] CH_HIGH2 = 8'hC0;
  localparam logic [7:0] CH_ALL = 8'hFF;

  typedef enum logic [1:0] {
    SEQ_IDLE = 2'h0,
    SEQ_DIGITAL = 2'h1,
    SEQ_ANALOG = 2'h3,
    SEQ_DONE = 2'h2
  } seq_state_t;

  typedef struct packed {
    logic ext_off;
    logic all_off;
    logic ch6_off;
    logic hbridge;
  } sources_t;

  typedef struct packed {
    logic shutoff_in_event;
    logic shutoff_pin_event;
    logic feedback_pulldown_ov_event;
    logic feedback_pulldown_uv_event;
    logic pulldown_protect_event;
    logic supply_high_shutoff_event;
    logic supply_high_glitch_event;
    logic supply_low_shutoff_event;
    logic por_event;
    logic battery_low_event;
  } flags_t;

  typedef struct packed {
    logic shutoff_in_level;
    logic shutoff_pin_level;
    logic supply_high_level;
    logic supply_low_level;
    logic battery_low_level;
  } levels_t;

  typedef struct packed {
    logic [15:0] cnt;
    logic filt;
  } filter_state_t;

  typedef struct packed {
    seq_state_t seq;
    logic [2:0] digital_selftest_step;
    logic [15:0] seq_cnt;
    logic digital_selftest_err;
    logic selftest_done;
    logic selftest_fail;
    logic selfcheck_done;
    logic selfcheck_shutoff;
    logic selfcheck_seen;
    logic [3:0] timer_probe;
    logic [3:0] timer_probe_q;
    logic ext_reset_q;
    logic drive_q;
    logic protect;
    logic pin_oe;
    logic ov_latched;
    logic uv_shut;
    logic [15:0] uv_hold_cnt;
    flags_t flags;
    levels_t levels;
    logic [7:0] chan_off;
    logic [7:0] chan_hiz;
  } ctl_state_t;

  localparam filter_state_t FILTER_RESET = '{cnt: 16'h0000, filt: 1'b0};
  localparam flags_t FLAGS_AT_POR = 10'h002;
  localparam ctl_state_t CTL_RESET = '{seq: SEQ_IDLE, flags: FLAGS_AT_POR, default: '0};

endpackage : shutoff_pkg

// [level_filter.sv]
`timescale 1ns/1ps
// Passes a high level only after it has held for LIMIT cycles; drops at once
module level_filter #(
  parameter logic [15:0] LIMIT = 16'h0001
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic level_i,
  output logic filt_o
);

  shutoff_pkg::filter_state_t st_ff;
  shutoff_pkg::filter_state_t nxt_st;

  // Count the held level, clear on any low
  always_comb begin
    nxt_st = st_ff;
    if (!level_i) begin
      nxt_st.cnt = 16'h0000;
      nxt_st.filt = 1'b0;
    end else if (st_ff.cnt >= LIMIT - 16'h0001) begin
      nxt_st.filt = 1'b1;
    end else begin
      nxt_st.cnt = st_ff.cnt + 16'h0001;
    end
  end

  // State register
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      st_ff <= shutoff_pkg::FILTER_RESET;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign filt_o = st_ff.filt;

endmodule : level_filter

// [shutoff_controller.sv]
`timescale 1ns/1ps
module shutoff_controller #(
  parameter int SELFCHECK_CYCLES_P = shutoff_pkg::SELFCHECK_CYCLES
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic shutoff_in_high_i,
  input wire logic shutoff_pin_low_n_i,
  output logic shutoff_pin_low_n_o,
  output logic shutoff_pin_low_n_oe_o,
  input wire logic pin_over_thresh_i,
  input wire logic ext_reset_n_i,
  input wire logic supply_high_cmp_i,
  input wire logic supply_low_cmp_i,
  input wire logic por_cmp_i,
  input wire logic battery_low_cmp_i,
  input wire logic channel6_enable_in_i,
  input wire logic hbridge78_i,
  input wire logic cc_fail_i,
  input wire logic selftest_request_i,
  input wire logic spi_read_i,
  output logic [7:0] chan_off_o,
  output logic [7:0] chan_hiz_o,
  output shutoff_pkg::flags_t flags_o,
  output shutoff_pkg::levels_t levels_o,
  output logic selftest_done_o,
  output logic selftest_fail_shutoff_o,
  output logic selfcheck_done_o,
  output logic selfcheck_shutoff_o,
  output logic selfcheck_stim_o,
  output logic cfg_reset_o
);

  localparam logic [15:0] SC_LAST = 16'(SELFCHECK_CYCLES_P - 1);

  shutoff_pkg::ctl_state_t st_ff;
  shutoff_pkg::ctl_state_t nxt_st;
  shutoff_pkg::sources_t live_src;
  logic filt_rst_n;
  logic analog;
  logic supply_high_eff;
  logic ov_filt;
  logic uv_filt;
  logic uv_pin_filt;
  logic batt_filt;
  logic pin_ov_filt;
  logic drive_req;
  logic start;
  logic err_now;

  // Combine shutoff sources into the actively-off channel mask
  function automatic logic [7:0] chan_off_mask(input shutoff_pkg::sources_t s);
    logic [7:0] m;
    m = shutoff_pkg::CH_NONE;
    if (s.all_off) begin
      m = shutoff_pkg::CH_ALL;
    end else begin
      if (s.ext_off) begin
        m = s.hbridge ? shutoff_pkg::CH_ALL : shutoff_pkg::CH_LOW6; // R6
      end
      if (s.ch6_off) begin
        m = m | shutoff_pkg::CH_SIX;
      end
    end
    return m;
  endfunction : chan_off_mask

  // Forced source pattern for each digital self-test step
  function automatic shutoff_pkg::sources_t digital_selftest_src(input logic [2:0] step);
    shutoff_pkg::sources_t s;
    s = '0;
    if (step == shutoff_pkg::DIGITAL_SELFTEST_CH6_STEP) begin
      s.ch6_off = 1'b1;
    end else if (step == shutoff_pkg::DIGITAL_SELFTEST_SUPPLY_STEP) begin
      s.all_off = 1'b1;
    end else begin
      s.ext_off = 1'b1;
    end
    return s;
  endfunction : digital_selftest_src

  // Mask that a healthy shutoff path must produce for each step
  function automatic logic [7:0] digital_selftest_expect(input logic [2:0] step);
    logic [7:0] m;
    m = shutoff_pkg::CH_LOW6;
    if (step == shutoff_pkg::DIGITAL_SELFTEST_CH6_STEP) begin
      m = shutoff_pkg::CH_SIX;
    end else if (step == shutoff_pkg::DIGITAL_SELFTEST_SUPPLY_STEP) begin
      m = shutoff_pkg::CH_ALL;
    end
    return m;
  endfunction : digital_selftest_expect

  // Power-on reset also clears the filters
  assign filt_rst_n = rst_n_i & ~por_cmp_i; // R11
  assign analog = (st_ff.seq == shutoff_pkg::SEQ_ANALOG);
  // Comparator is stimulated during the analog check, so hide it then
  assign supply_high_eff = supply_high_cmp_i & ~analog;

  level_filter #(.LIMIT(shutoff_pkg::SUPPLY_HIGH_LIMIT)) u_ov_filt (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(filt_rst_n),
    .level_i(supply_high_eff),
    .filt_o(ov_filt)
  );

  level_filter #(.LIMIT(shutoff_pkg::SUPPLY_LOW_LIMIT)) u_uv_filt (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(filt_rst_n),
    .level_i(supply_low_cmp_i),
    .filt_o(uv_filt)
  );

  // Extra delay before undervoltage reaches the pin
  level_filter #(.LIMIT(shutoff_pkg::SUPPLY_LOW_PIN_LIMIT)) u_uv_pin_filt (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(filt_rst_n),
    .level_i(uv_filt),
    .filt_o(uv_pin_filt)
  );

  level_filter #(.LIMIT(shutoff_pkg::BATTERY_LIMIT)) u_batt_filt (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(filt_rst_n),
    .level_i(battery_low_cmp_i),
    .filt_o(batt_filt)
  );

  // Pin overvoltage only counts while the pull-down is on
  level_filter #(.LIMIT(shutoff_pkg::PIN_OV_LIMIT)) u_pin_ov_filt (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(filt_rst_n),
    .level_i(pin_over_thresh_i & st_ff.pin_oe),
    .filt_o(pin_ov_filt)
  );

  // Live shutoff sources
  always_comb begin
    live_src.ext_off = shutoff_in_high_i | ~shutoff_pin_low_n_i | st_ff.ov_latched // R1 R3 R8
      | st_ff.uv_shut | cc_fail_i | st_ff.selftest_fail | st_ff.selfcheck_shutoff; // R10 R18
    live_src.all_off = batt_filt; // R20
    live_src.ch6_off = ~channel6_enable_in_i;
    live_src.hbridge = hbridge78_i;
  end

  // Pin feedback request and sequence triggers
  assign drive_req = ext_reset_n_i & (ov_filt | uv_pin_filt); // R4 R5
  assign start = ext_reset_n_i & (~st_ff.ext_reset_q | selftest_request_i); // R13
  assign err_now = (chan_off_mask(digital_selftest_src(st_ff.digital_selftest_step)) != digital_selftest_expect(st_ff.digital_selftest_step))
    | ((st_ff.digital_selftest_step == shutoff_pkg::DIGITAL_SELFTEST_LAST_STEP)
       & (st_ff.timer_probe != st_ff.timer_probe_q)); // R15

  // Next-state logic
  always_comb begin
    nxt_st = st_ff;
    nxt_st.ext_reset_q = ext_reset_n_i;
    nxt_st.drive_q = drive_req;
    nxt_st.timer_probe_q = st_ff.timer_probe;
    // Sticky flags: set wins over the read clear
    nxt_st.flags = spi_read_i ? '0 : st_ff.flags; // R22
    nxt_st.flags.shutoff_in_event = nxt_st.flags.shutoff_in_event | shutoff_in_high_i; // R2
    nxt_st.flags.shutoff_pin_event = nxt_st.flags.shutoff_pin_event
      | ~shutoff_pin_low_n_i; // R3
    nxt_st.flags.feedback_pulldown_ov_event = nxt_st.flags.feedback_pulldown_ov_event
      | (ext_reset_n_i & ov_filt); // R4
    nxt_st.flags.feedback_pulldown_uv_event = nxt_st.flags.feedback_pulldown_uv_event
      | (ext_reset_n_i & uv_pin_filt); // R4
    nxt_st.flags.supply_high_shutoff_event = nxt_st.flags.supply_high_shutoff_event
      | ov_filt; // R8
    nxt_st.flags.supply_high_glitch_event = nxt_st.flags.supply_high_glitch_event
      | supply_high_eff; // R9
    nxt_st.flags.supply_low_shutoff_event = nxt_st.flags.supply_low_shutoff_event
      | uv_filt; // R10
    nxt_st.flags.battery_low_event = nxt_st.flags.battery_low_event | batt_filt; // R20
    // Live levels
    nxt_st.levels.shutoff_in_level = shutoff_in_high_i; // R2
    nxt_st.levels.shutoff_pin_level = shutoff_pin_low_n_i; // R3
    nxt_st.levels.supply_high_level = supply_high_cmp_i;
    nxt_st.levels.supply_low_level = supply_low_cmp_i;
    nxt_st.levels.battery_low_level = battery_low_cmp_i; // R20
    // Overvoltage shutoff held until the next readout
    nxt_st.ov_latched = ov_filt | (st_ff.ov_latched & ~spi_read_i); // R8
    // Undervoltage shutoff lingers for the filter time after clearing
    if (uv_filt) begin
      nxt_st.uv_shut = 1'b1; // R10
      nxt_st.uv_hold_cnt = 16'h0000;
    end else if (st_ff.uv_shut) begin
      if (st_ff.uv_hold_cnt >= shutoff_pkg::SUPPLY_LOW_LIMIT - 16'h0001) begin
        nxt_st.uv_shut = 1'b0; // R10
        nxt_st.uv_hold_cnt = 16'h0000;
      end else begin
        nxt_st.uv_hold_cnt = st_ff.uv_hold_cnt + 16'h0001;
      end
    end
    // Pull-down protection: set on pin overvoltage, cleared by new activation
    if (drive_req & ~st_ff.drive_q) begin
      nxt_st.protect = 1'b0; // R7
    end else if (pin_ov_filt & st_ff.pin_oe) begin
      nxt_st.protect = 1'b1; // R7
      nxt_st.flags.pulldown_protect_event = 1'b1; // R7
    end
    nxt_st.pin_oe = drive_req & ~nxt_st.protect; // R4 R7
    // Self-test timer used to prove timers can be stopped
    if ((st_ff.seq == shutoff_pkg::SEQ_DIGITAL)
        & (st_ff.digital_selftest_step == shutoff_pkg::DIGITAL_SELFTEST_TIMER_RUN_STEP)) begin
      nxt_st.timer_probe = st_ff.timer_probe + 4'h1; // R15
    end
    // Self-test sequence
    case (st_ff.seq)
      shutoff_pkg::SEQ_DIGITAL: begin
        nxt_st.digital_selftest_err = st_ff.digital_selftest_err | err_now; // R15
        if (st_ff.digital_selftest_step == shutoff_pkg::DIGITAL_SELFTEST_LAST_STEP) begin
          nxt_st.selftest_done = 1'b1; // R16
          nxt_st.selftest_fail = st_ff.digital_selftest_err | err_now; // R16
          nxt_st.seq = shutoff_pkg::SEQ_ANALOG; // R12
          nxt_st.seq_cnt = 16'h0000;
          nxt_st.selfcheck_shutoff = 1'b1; // R17
          nxt_st.selfcheck_seen = 1'b0;
        end else begin
          nxt_st.digital_selftest_step = st_ff.digital_selftest_step + 3'h1;
        end
      end
      shutoff_pkg::SEQ_ANALOG: begin
        nxt_st.selfcheck_seen = st_ff.selfcheck_seen | supply_high_cmp_i;
        if (st_ff.seq_cnt >= SC_LAST) begin
          nxt_st.selfcheck_done = 1'b1; // R17
          nxt_st.selfcheck_shutoff = ~(st_ff.selfcheck_seen | supply_high_cmp_i); // R18
          nxt_st.seq = shutoff_pkg::SEQ_DONE;
        end else begin
          nxt_st.seq_cnt = st_ff.seq_cnt + 16'h0001;
        end
      end
      shutoff_pkg::SEQ_IDLE, shutoff_pkg::SEQ_DONE: begin
        if (start) begin
          nxt_st.seq = shutoff_pkg::SEQ_DIGITAL; // R13
          nxt_st.digital_selftest_step = 3'h0;
          nxt_st.digital_selftest_err = 1'b0;
          nxt_st.selftest_done = 1'b0; // R14
          nxt_st.selftest_fail = 1'b0;
          nxt_st.selfcheck_done = 1'b0;
          nxt_st.selfcheck_shutoff = 1'b0;
          nxt_st.protect = 1'b0; // R14
        end
      end
      default: begin
        nxt_st.seq = shutoff_pkg::SEQ_IDLE;
      end
    endcase
    // External reset low aborts a running sequence
    if (!ext_reset_n_i
        && (st_ff.seq == shutoff_pkg::SEQ_DIGITAL || st_ff.seq == shutoff_pkg::SEQ_ANALOG)) begin
      nxt_st.seq = shutoff_pkg::SEQ_IDLE; // R19
    end
    // Output drive state
    if (nxt_st.seq == shutoff_pkg::SEQ_DIGITAL) begin
      nxt_st.chan_off = shutoff_pkg::CH_NONE; // R14
      nxt_st.chan_hiz = shutoff_pkg::CH_ALL; // R14
    end else begin
      nxt_st.chan_off = chan_off_mask(live_src); // R1 R3 R6 R16 R18 R20
      // Check shutoff holds 1-6 off from the very cycle the analog check starts
      if (nxt_st.selfcheck_shutoff) begin
        nxt_st.chan_off = nxt_st.chan_off
          | (hbridge78_i ? shutoff_pkg::CH_ALL : shutoff_pkg::CH_LOW6); // R17
      end
      nxt_st.chan_hiz = (nxt_st.seq == shutoff_pkg::SEQ_ANALOG)
        ? (shutoff_pkg::CH_HIGH2 & ~nxt_st.chan_off) : shutoff_pkg::CH_NONE; // R16 R17
    end
    // Power-on reset sets the POR flag and clears all else but the reset pin history, so it starts no test
    if (por_cmp_i) begin
      nxt_st = shutoff_pkg::CTL_RESET; // R11 R19
      nxt_st.ext_reset_q = ext_reset_n_i; // R13
    end
  end

  // State register
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      st_ff <= shutoff_pkg::CTL_RESET;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Outputs
  assign shutoff_pin_low_n_o = 1'b0;
  assign shutoff_pin_low_n_oe_o = st_ff.pin_oe;
  assign chan_off_o = st_ff.chan_off;
  assign chan_hiz_o = st_ff.chan_hiz;
  assign flags_o = st_ff.flags;
  assign levels_o = st_ff.levels;
  assign selftest_done_o = st_ff.selftest_done;
  assign selftest_fail_shutoff_o = st_ff.selftest_fail;
  assign selfcheck_done_o = st_ff.selfcheck_done;
  assign selfcheck_shutoff_o = st_ff.selfcheck_shutoff;
  assign selfcheck_stim_o = analog;
  assign cfg_reset_o = (st_ff.seq == shutoff_pkg::SEQ_DIGITAL);

  // Checks
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!rst_n_i || por_cmp_i);

  in_forces_off_a: assert property ( // R1
    shutoff_in_high_i |=> (chan_off_o[5:0] == 6'h3F) || cfg_reset_o)
    else $error("shutoff input did not force channels 1-6 off");

  in_event_a: assert property ( // R2
    shutoff_in_high_i |=> flags_o.shutoff_in_event && levels_o.shutoff_in_level)
    else $error("shutoff input event or level missing");

  pin_gate_a: assert property ( // R4
    !ext_reset_n_i |=> !shutoff_pin_low_n_oe_o)
    else $error("pin pulled while external reset low");

  ov_pin_drive_a: assert property ( // R5
    $rose(ov_filt) && ext_reset_n_i && !st_ff.protect |=> shutoff_pin_low_n_oe_o)
    else $error("overvoltage did not pull pin low");

  protect_release_a: assert property ( // R7
    pin_ov_filt && st_ff.pin_oe && $stable(drive_req) && drive_req
    |=> !shutoff_pin_low_n_oe_o && flags_o.pulldown_protect_event)
    else $error("pin protection did not release pull-down");

  ov_hold_a: assert property ( // R8
    st_ff.ov_latched && !spi_read_i |=> st_ff.ov_latched ##0 (chan_off_o[5:0] == 6'h3F
      || cfg_reset_o))
    else $error("overvoltage shutoff released before read");

  glitch_flag_a: assert property ( // R9
    supply_high_cmp_i && !selfcheck_stim_o |=> flags_o.supply_high_glitch_event)
    else $error("overvoltage glitch flag missing");

  uv_linger_a: assert property ( // R10
    $fell(uv_filt) |-> st_ff.uv_shut [*8])
    else $error("undervoltage shutoff dropped too early");

  digital_selftest_hiz_a: assert property ( // R14
    cfg_reset_o |-> (chan_hiz_o == 8'hFF) && (chan_off_o == 8'h00) && !selftest_done_o)
    else $error("outputs not three-stated during digital test");

  digital_selftest_end_a: assert property ( // R16
    $fell(cfg_reset_o) && $past(ext_reset_n_i) |-> selftest_done_o && selfcheck_stim_o)
    else $error("digital test end not flagged");

  abort_a: assert property ( // R19
    !ext_reset_n_i |=> !cfg_reset_o && !selfcheck_stim_o)
    else $error("sequence not aborted by external reset");

  batt_off_a: assert property ( // R20
    batt_filt |=> (chan_off_o == 8'hFF) || cfg_reset_o)
    else $error("battery undervoltage did not turn outputs off");

  seq_done_c: cover property ($rose(selfcheck_done_o));
  seq_fail_c: cover property ($rose(selfcheck_done_o) && selfcheck_shutoff_o);
  protect_c: cover property ($rose(st_ff.protect));
  uv_shut_c: cover property ($fell(st_ff.uv_shut));

endmodule : shutoff_controller

// [mcu_model.sv]
`timescale 1ns/1ps
// Controller side of the two-way shutoff pin, with the wire resolved here
module mcu_model (
  input wire logic ref_clk_i,
  input wire logic pull_low_i,
  input wire logic dev_val_i,
  input wire logic dev_oe_i,
  output logic pin_level_o
);
  logic drive_low_ff;
  // Controller changes its pin drive only just after a clock edge
  always_ff @(posedge ref_clk_i) begin
    drive_low_ff <= pull_low_i;
  end
  // Any party pulling low wins; otherwise the controller holds the pin high
  assign pin_level_o = ((dev_oe_i && !dev_val_i) || drive_low_ff) ? 1'b0 : 1'b1;
endmodule : mcu_model

// [output_shutoff_safety_controller_tb.sv]
`timescale 1ns/1ps
module output_shutoff_safety_controller_tb;
  localparam int SC = 20;
  localparam int BL = int'(shutoff_pkg::BATTERY_LIMIT);
  localparam int HL = int'(shutoff_pkg::SUPPLY_HIGH_LIMIT);
  localparam int PL = int'(shutoff_pkg::PIN_OV_LIMIT);
  localparam int UL = int'(shutoff_pkg::SUPPLY_LOW_LIMIT);
  localparam int UP = int'(shutoff_pkg::SUPPLY_LOW_PIN_LIMIT);
  logic ref_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic sh_in = 1'b0, pin_req = 1'b0, ot = 1'b0, ext_n = 1'b1, sup_hi = 1'b0, sup_lo = 1'b0;
  logic por = 1'b0, bat = 1'b0, en6 = 1'b1, hb = 1'b0, cc = 1'b0, rq = 1'b0, rd = 1'b0;
  logic stim_ok = 1'b1;
  logic pin_lvl, pin_val, oe, st_done, st_fail, sc_done, sc_shut, stim, cfg_rst;
  logic [7:0] chan_off, chan_hiz;
  shutoff_pkg::flags_t flags;
  shutoff_pkg::levels_t levels;
  int error_cnt = 0;
  int checks = 0;
  int n;

  // The analog check sees the comparator trip only when stim_ok is set
  shutoff_controller #(.SELFCHECK_CYCLES_P(SC)) i_shutoff_controller (
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .shutoff_in_high_i(sh_in),
    .shutoff_pin_low_n_i(pin_lvl), .shutoff_pin_low_n_o(pin_val),
    .shutoff_pin_low_n_oe_o(oe), .pin_over_thresh_i(ot), .ext_reset_n_i(ext_n),
    .supply_high_cmp_i(sup_hi | (stim & stim_ok)), .supply_low_cmp_i(sup_lo),
    .por_cmp_i(por), .battery_low_cmp_i(bat), .channel6_enable_in_i(en6),
    .hbridge78_i(hb), .cc_fail_i(cc), .selftest_request_i(rq), .spi_read_i(rd),
    .chan_off_o(chan_off), .chan_hiz_o(chan_hiz), .flags_o(flags), .levels_o(levels),
    .selftest_done_o(st_done), .selftest_fail_shutoff_o(st_fail),
    .selfcheck_done_o(sc_done), .selfcheck_shutoff_o(sc_shut),
    .selfcheck_stim_o(stim), .cfg_reset_o(cfg_rst)
  );
  mcu_model i_mcu_model (
    .ref_clk_i(ref_clk_i), .pull_low_i(pin_req), .dev_val_i(pin_val), .dev_oe_i(oe),
    .pin_level_o(pin_lvl)
  );

  // Clock of 4 ns period
  initial begin
    forever #2 ref_clk_i = ~ref_clk_i;
  end

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic step(input int k);
    repeat (k) @(posedge ref_clk_i);
    #1;
  endtask : step

  // One read frame clears the sticky flags
  task automatic spi_read();
    rd = 1'b1;
    step(1);
    rd = 1'b0;
  endtask : spi_read

  task automatic pulse_request();
    rq = 1'b1;
    step(1);
    rq = 1'b0;
  endtask : pulse_request

  // Waits for done of the digital (0) or analog (1) stage, counting cycles
  task automatic wait_stage(input int which);
    n = 0;
    while (((which == 0) ? st_done : sc_done) !== 1'b1 && n < 400) begin
      step(1);
      n++;
    end
    check("stage_wait", 8'(n < 400), 8'h01);
  endtask : wait_stage

  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : complete_run

  // Follows an already started self-test sequence to its end; pass tells the expected analog outcome
  task automatic run_sequence(input logic pass);
    wait_stage(0);
    check("selftest_fail", 8'(st_fail), 8'h00);
    check("check_shutoff", 8'(sc_shut), 8'h01);
    check("off_in_check", chan_off, shutoff_pkg::CH_LOW6);
    wait_stage(1);
    check("check_length", 8'(n >= SC && n <= SC + 2), 8'h01);
    check("check_result", 8'(sc_shut), 8'(!pass));
    step(2);
    check("off_after", chan_off, pass ? 8'h00 : shutoff_pkg::CH_LOW6);
  endtask : run_sequence

  initial begin
    repeat (20000) @(posedge ref_clk_i);
    error_cnt++;
    complete_run();
  end

  initial begin
    step(6);
    check("por_at_reset", 8'(flags.por_event), 8'h01);
    rst_n_i = 1'b1;
    step(2);
    check("cfg_reset", 8'(cfg_rst), 8'h01);
    check("hiz_in_test", chan_hiz, shutoff_pkg::CH_ALL);
    check("done_cleared", 8'(st_done), 8'h00);
    run_sequence(1'b1);
    check("hiz_after", chan_hiz, 8'h00);
    $display("test selftest end");
    spi_read();
    check("por_cleared", 8'(flags.por_event), 8'h00);
    sh_in = 1'b1;
    step(2);
    check("in_off", chan_off, shutoff_pkg::CH_LOW6);
    check("in_level", 8'(levels.shutoff_in_level), 8'h01);
    check("in_event", 8'(flags.shutoff_in_event), 8'h01);
    hb = 1'b1;
    step(2);
    check("in_off_bridge", chan_off, shutoff_pkg::CH_ALL);
    sh_in = 1'b0;
    hb = 1'b0;
    step(2);
    check("in_release", chan_off, 8'h00);
    spi_read();
    check("in_event_read", 8'(flags.shutoff_in_event), 8'h00);
    pin_req = 1'b1;
    step(3);
    check("pin_off", chan_off, shutoff_pkg::CH_LOW6);
    check("pin_event", 8'(flags.shutoff_pin_event), 8'h01);
    check("pin_level", 8'(levels.shutoff_pin_level), 8'h00);
    pin_req = 1'b0;
    step(3);
    check("pin_release", chan_off, 8'h00);
    en6 = 1'b0;
    step(2);
    check("ch6_off", chan_off, shutoff_pkg::CH_SIX);
    en6 = 1'b1;
    cc = 1'b1;
    step(2);
    check("cc_off", chan_off, shutoff_pkg::CH_LOW6);
    cc = 1'b0;
    step(2);
    check("cc_release", chan_off, 8'h00);
    $display("test shutoff inputs end");
    bat = 1'b1;
    step(BL - 2);
    check("bat_filtered", chan_off, 8'h00);
    step(5);
    check("bat_off", chan_off, shutoff_pkg::CH_ALL);
    check("bat_event", 8'(flags.battery_low_event), 8'h01);
    check("bat_level", 8'(levels.battery_low_level), 8'h01);
    bat = 1'b0;
    step(3);
    check("bat_release", chan_off, 8'h00);
    $display("test battery end");
    spi_read();
    sup_hi = 1'b1;
    step(3);
    sup_hi = 1'b0;
    step(2);
    check("glitch_event", 8'(flags.supply_high_glitch_event), 8'h01);
    check("glitch_no_off", chan_off, 8'h00);
    spi_read();
    sup_hi = 1'b1;
    step(HL + 3);
    check("ov_off", chan_off, shutoff_pkg::CH_LOW6);
    check("ov_pulldown", 8'(oe), 8'h01);
    check("ov_event", 8'(flags.supply_high_shutoff_event), 8'h01);
    check("ov_level", 8'(levels.supply_high_level), 8'h01);
    check("fb_event", 8'(flags.feedback_pulldown_ov_event), 8'h01);
    ot = 1'b1;
    step(PL + 5);
    check("protect_release", 8'(oe), 8'h00);
    check("protect_event", 8'(flags.pulldown_protect_event), 8'h01);
    ot = 1'b0;
    sup_hi = 1'b0;
    step(3);
    check("ov_held", chan_off, shutoff_pkg::CH_LOW6);
    spi_read();
    step(2);
    check("ov_read_release", chan_off, 8'h00);
    $display("test supply high end");
    sup_lo = 1'b1;
    step(UL + 3);
    check("uv_off", chan_off, shutoff_pkg::CH_LOW6);
    check("uv_event", 8'(flags.supply_low_shutoff_event), 8'h01);
    check("uv_level", 8'(levels.supply_low_level), 8'h01);
    check("uv_pin_wait", 8'(oe), 8'h00);
    step(UP);
    check("uv_pulldown", 8'(oe), 8'h01);
    check("uv_fb_event", 8'(flags.feedback_pulldown_uv_event), 8'h01);
    sup_lo = 1'b0;
    step(UL - 5);
    check("uv_linger", chan_off, shutoff_pkg::CH_LOW6);
    step(10);
    check("uv_release", chan_off, 8'h00);
    $display("test supply low end");
    stim_ok = 1'b0;
    pulse_request();
    run_sequence(1'b0);
    pulse_request();
    step(3);
    check("rerun_started", 8'(cfg_rst), 8'h01);
    ext_n = 1'b0;
    step(2);
    check("abort_cfg", 8'(cfg_rst), 8'h00);
    check("abort_done", 8'(st_done), 8'h00);
    stim_ok = 1'b1;
    ext_n = 1'b1;
    run_sequence(1'b1);
    $display("test selftest fail and abort end");
    por = 1'b1;
    step(2);
    por = 1'b0;
    step(1);
    check("por_event", 8'(flags.por_event), 8'h01);
    check("por_no_start", 8'(cfg_rst), 8'h00);
    $display("test power on end");
    complete_run();
  end
endmodule : output_shutoff_safety_controller_tb
